//--- shared/sestc_pkg.sv
// Constants, field layouts and carrier types for the serial error/status block
// Assumes an APB slave with 32-bit data and one aligned word per register
package sestc_pkg;

	// Register indices, byte address is four times the index
	localparam logic [23:0] SESTC_IDX_CONTROL = 24'hFFF602;
	localparam logic [23:0] SESTC_IDX_STATUS  = 24'hFFF604;
	localparam logic [23:0] SESTC_IDX_IRQ_ST  = 24'hFFF610;
	localparam logic [23:0] SESTC_IDX_IRQ_MSK = 24'hFFF611;
	localparam logic [31:0] SESTC_ADDR_CONTROL = {6'h00, SESTC_IDX_CONTROL, 2'h0};
	localparam logic [31:0] SESTC_ADDR_STATUS  = {6'h00, SESTC_IDX_STATUS, 2'h0};
	localparam logic [31:0] SESTC_ADDR_IRQ_ST  = {6'h00, SESTC_IDX_IRQ_ST, 2'h0};
	localparam logic [31:0] SESTC_ADDR_IRQ_MSK = {6'h00, SESTC_IDX_IRQ_MSK, 2'h0};

	// Control bits
	localparam int SESTC_CTL_TXI_EN  = 7;
	localparam int SESTC_CTL_RXI_EN  = 6;
	localparam int SESTC_CTL_TX_EN   = 5;
	localparam int SESTC_CTL_RX_EN   = 4;
	localparam int SESTC_CTL_TEI_EN  = 2;
	// Status bits
	localparam int SESTC_ST_TXE  = 7;
	localparam int SESTC_ST_RXF  = 6;
	localparam int SESTC_ST_OVR  = 5;
	localparam int SESTC_ST_FRM  = 4;
	localparam int SESTC_ST_PAR  = 3;
	localparam int SESTC_ST_TEND = 2;
	// Event bits in the irq status and mask registers
	localparam int SESTC_EV_RXF  = 0;
	localparam int SESTC_EV_ERR  = 1;
	localparam int SESTC_EV_TXE  = 2;
	localparam int SESTC_EV_TEND = 3;
	localparam int SESTC_EV_N    = 4;

	localparam logic [7:0] SESTC_CONTROL_RST = 8'h00;
	localparam logic [7:0] SESTC_STATUS_RST  = 8'h84;
	localparam logic [3:0] SESTC_EV_RST      = 4'h0;
	localparam logic [2:0] SESTC_ERR_MASK_RST = 3'h0;
	localparam int SESTC_FLAG_CELLS = 3;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [31:0] paddr;
		logic [31:0] pwdata;
	} sestc_apb_req_t;

	typedef struct packed {
		logic overrun;
		logic framing;
		logic parity;
		logic rx_done;
		logic tx_load;
		logic tx_end;
	} sestc_rx_ev_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
		logic [7:0]  control;
		logic        tx_buf_empty_flag;
		logic        rx_full_flag;
		logic        tx_end_flag;
		logic [3:0]  ev_status;
		logic [3:0]  ev_mask;
		logic        irq;
		logic        rx_req;
		logic        err_req;
		logic        tx_done_req;
		logic        drop_char;
	} sestc_state_t;

endpackage

//--- logic/sestc_err_flag.sv
// Sticky error flags with read-then-write-zero clear
// Assumes same clock; read_pulse marks the cycle the status read data is captured, the cycle before pready
`timescale 1ns/100ps
module sestc_err_flag (
	input  wire logic                                  clock,
	input  wire logic                                  sys_rst,
	input  wire logic                                  clk_en,
	input  wire logic [sestc_pkg::SESTC_FLAG_CELLS-1:0] set_in,
	input  wire logic                                  read_pulse,
	input  wire logic                                  write_pulse,
	input  wire logic [sestc_pkg::SESTC_FLAG_CELLS-1:0] wdata,
	output logic      [sestc_pkg::SESTC_FLAG_CELLS-1:0] flag
);

	typedef struct packed {
		logic [sestc_pkg::SESTC_FLAG_CELLS-1:0] flag;
		logic [sestc_pkg::SESTC_FLAG_CELLS-1:0] armed;
	} sestc_flag_state_t;

	sestc_flag_state_t st;
	sestc_flag_state_t next_st;

	// ==========================================
	// Per-flag cells
	always_comb begin
		next_st = st;
		for (int i = 0; i < sestc_pkg::SESTC_FLAG_CELLS; i++) begin
			if (read_pulse) begin
				next_st.armed[i] = st.flag[i];
			end
			if (write_pulse && !wdata[i] && st.armed[i]) begin
				next_st.flag[i]  = 1'b0;
				next_st.armed[i] = 1'b0;
			end
			if (set_in[i]) begin
				next_st.flag[i] = 1'b1;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			st <= '0;
		end else if (clk_en) begin
			st <= next_st;
		end
	end

	assign flag = st.flag;

endmodule // sestc_err_flag

//--- logic/sestc_top.sv
// Serial channel error flags, transmit control and interrupt logic
// Assumes an APB master and receiver/transmitter event strobes on the same clock
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/100ps
module sestc_top (
	input  wire logic                  clock,
	input  wire logic                  sys_rst,
	input  wire logic                  clk_en,
	input  wire sestc_pkg::sestc_apb_req_t apb_req,
	input  wire sestc_pkg::sestc_rx_ev_t   rx_ev,
	output logic [31:0]                prdata,
	output logic                       pready,
	output logic                       pslverr,
	output logic                       tx_enable,
	output logic                       rx_enable,
	output logic                       rx_irq_req,
	output logic                       err_irq_req,
	output logic                       tx_done_irq_req,
	output logic                       drop_char,
	output logic                       irq
);

	sestc_pkg::sestc_state_t st;
	sestc_pkg::sestc_state_t next_st;
	logic [2:0]  err_flags;
	logic [2:0]  err_set;
	logic        wr_stb;
	logic        rd_status;
	logic        wr_status;
	logic [7:0]  status_view;
	logic [3:0]  ev_hit;

	// ==========================================
	// Bus decode
	assign wr_stb    = apb_req.psel && apb_req.penable && st.pready && apb_req.pwrite;
	// Arm on the cycle the read data is captured, so software saw exactly these flags
	assign rd_status = apb_req.psel && apb_req.penable && !st.pready && !apb_req.pwrite
		&& apb_req.paddr == sestc_pkg::SESTC_ADDR_STATUS;
	assign wr_status = wr_stb && apb_req.paddr == sestc_pkg::SESTC_ADDR_STATUS;

	// ==========================================
	// Error events
	always_comb begin
		err_set = 3'h0;
		err_set[2] = rx_ev.overrun || (rx_ev.rx_done && st.rx_full_flag);
		err_set[1] = rx_ev.framing && rx_ev.rx_done;
		err_set[0] = rx_ev.parity && rx_ev.rx_done;
	end

	sestc_err_flag u_err (
		.clock       (clock),
		.sys_rst     (sys_rst),
		.clk_en      (clk_en),
		.set_in      (err_set),
		.read_pulse  (rd_status),
		.write_pulse (wr_status),
		.wdata       ({apb_req.pwdata[sestc_pkg::SESTC_ST_OVR],
		               apb_req.pwdata[sestc_pkg::SESTC_ST_FRM],
		               apb_req.pwdata[sestc_pkg::SESTC_ST_PAR]}),
		.flag        (err_flags)
	);

	always_comb begin
		status_view = 8'h00;
		status_view[sestc_pkg::SESTC_ST_TXE]  = st.tx_buf_empty_flag;
		status_view[sestc_pkg::SESTC_ST_RXF]  = st.rx_full_flag;
		status_view[sestc_pkg::SESTC_ST_OVR]  = err_flags[2];
		status_view[sestc_pkg::SESTC_ST_FRM]  = err_flags[1];
		status_view[sestc_pkg::SESTC_ST_PAR]  = err_flags[0];
		status_view[sestc_pkg::SESTC_ST_TEND] = st.tx_end_flag;
	end

	// ==========================================
	// Next state
	always_comb begin
		next_st = st;
		next_st.pready    = 1'b0;
		next_st.pslverr   = 1'b0;
		next_st.drop_char = 1'b0;
		ev_hit = 4'h0;
		// One wait cycle: ready is set at the end of the first access cycle, high in the second
		if (apb_req.psel && apb_req.penable && !st.pready) begin
			next_st.pready = 1'b1;
			next_st.prdata = 32'h0000_0000;
			if (apb_req.paddr == sestc_pkg::SESTC_ADDR_CONTROL) begin
				next_st.prdata = {24'h000000, st.control};
			end else if (apb_req.paddr == sestc_pkg::SESTC_ADDR_STATUS) begin
				next_st.prdata = {24'h000000, status_view};
			end else if (apb_req.paddr == sestc_pkg::SESTC_ADDR_IRQ_ST) begin
				next_st.prdata = {28'h0000000, st.ev_status};
			end else if (apb_req.paddr == sestc_pkg::SESTC_ADDR_IRQ_MSK) begin
				next_st.prdata = {28'h0000000, st.ev_mask};
			end else begin
				next_st.pslverr = 1'b1;
			end
		end
		// Receive full flag; a completed reception while full is dropped
		if (rx_ev.rx_done) begin
			if (st.rx_full_flag) begin
				next_st.drop_char = 1'b1;
			end else if (!rx_ev.framing && !rx_ev.parity) begin
				next_st.rx_full_flag = 1'b1;
				ev_hit[sestc_pkg::SESTC_EV_RXF] = 1'b1;
			end
		end
		if (|err_set) begin
			ev_hit[sestc_pkg::SESTC_EV_ERR] = 1'b1;
		end
		if (rx_ev.tx_load && st.control[sestc_pkg::SESTC_CTL_TX_EN]) begin
			next_st.tx_buf_empty_flag = 1'b1;
			next_st.tx_end_flag = 1'b0;
			ev_hit[sestc_pkg::SESTC_EV_TXE] = 1'b1;
		end
		if (rx_ev.tx_end && st.control[sestc_pkg::SESTC_CTL_TX_EN]) begin
			next_st.tx_end_flag = 1'b1;
			ev_hit[sestc_pkg::SESTC_EV_TEND] = 1'b1;
		end
		// Register writes
		if (wr_stb) begin
			if (apb_req.paddr == sestc_pkg::SESTC_ADDR_CONTROL) begin
				next_st.control = apb_req.pwdata[7:0];
				if (!apb_req.pwdata[sestc_pkg::SESTC_CTL_TX_EN]) begin
					next_st.tx_buf_empty_flag = 1'b1;
					next_st.tx_end_flag = 1'b1;
				end
			end else if (apb_req.paddr == sestc_pkg::SESTC_ADDR_STATUS) begin
				// Only zero writes clear; ones are ignored
				if (!apb_req.pwdata[sestc_pkg::SESTC_ST_RXF] && !rx_ev.rx_done) begin
					next_st.rx_full_flag = 1'b0;
				end
				if (!apb_req.pwdata[sestc_pkg::SESTC_ST_TXE] && !rx_ev.tx_load
					&& st.control[sestc_pkg::SESTC_CTL_TX_EN]) begin
					next_st.tx_buf_empty_flag = 1'b0;
				end
			end else if (apb_req.paddr == sestc_pkg::SESTC_ADDR_IRQ_ST) begin
				next_st.ev_status = st.ev_status & ~apb_req.pwdata[3:0];
			end else if (apb_req.paddr == sestc_pkg::SESTC_ADDR_IRQ_MSK) begin
				next_st.ev_mask = apb_req.pwdata[3:0];
			end
		end
		next_st.ev_status = next_st.ev_status | ev_hit;
		// Request lines follow the enables
		next_st.rx_req = next_st.rx_full_flag && next_st.control[sestc_pkg::SESTC_CTL_RXI_EN];
		next_st.err_req = (|err_flags || |err_set)
			&& next_st.control[sestc_pkg::SESTC_CTL_RXI_EN];
		next_st.tx_done_req = next_st.tx_end_flag
			&& next_st.control[sestc_pkg::SESTC_CTL_TEI_EN];
		next_st.irq = |(next_st.ev_status & next_st.ev_mask);
	end

	// ==========================================
	// State register
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			st <= '0;
			st.control <= sestc_pkg::SESTC_CONTROL_RST;
			st.tx_buf_empty_flag <= sestc_pkg::SESTC_STATUS_RST[sestc_pkg::SESTC_ST_TXE];
			st.tx_end_flag <= sestc_pkg::SESTC_STATUS_RST[sestc_pkg::SESTC_ST_TEND];
			st.ev_status <= sestc_pkg::SESTC_EV_RST;
			st.ev_mask <= sestc_pkg::SESTC_EV_RST;
		end else if (clk_en) begin
			st <= next_st;
		end
	end

	// ==========================================
	// Outputs
	assign prdata          = st.prdata;
	assign pready          = st.pready;
	assign pslverr         = st.pslverr;
	assign tx_enable       = st.control[sestc_pkg::SESTC_CTL_TX_EN];
	assign rx_enable       = st.control[sestc_pkg::SESTC_CTL_RX_EN];
	assign rx_irq_req      = st.rx_req;
	assign err_irq_req     = st.err_req;
	assign tx_done_irq_req = st.tx_done_req;
	assign drop_char       = st.drop_char;
	assign irq             = st.irq;

endmodule // sestc_top

//--- test/sestc_remote.sv
// Remote serial device: turns a bench command into one-cycle line events
// Assumes the bench changes kind just after a rising edge
`timescale 1ns/100ps
// ====================================================
// Event source
module sestc_remote (
	input  wire logic             clock,
	input  wire logic [2:0]       kind,
	output sestc_pkg::sestc_rx_ev_t ev
);
	always_ff @(posedge clock) begin
		ev <= '0;
		case (kind)
			3'h1: ev.overrun <= 1'b1;
			3'h2: ev <= '{framing: 1'b1, rx_done: 1'b1, default: 1'b0};
			3'h3: ev <= '{parity: 1'b1, rx_done: 1'b1, default: 1'b0};
			3'h4: ev.rx_done <= 1'b1;
			3'h5: ev.tx_load <= 1'b1;
			3'h6: ev.tx_end <= 1'b1;
			default: ;
		endcase
	end
endmodule // sestc_remote

//--- test/sestc_checker.sv
// Port assertions for the serial status block
// Assumes binding to sestc_top
`timescale 1ns/100ps
// ====================================================
// Checker
module sestc_checker (
	input wire logic                     clock,
	input wire logic                     sys_rst,
	input wire logic                     clk_en,
	input wire sestc_pkg::sestc_apb_req_t apb_req,
	input wire sestc_pkg::sestc_rx_ev_t   rx_ev,
	input wire logic [31:0]              prdata,
	input wire logic                     pready,
	input wire logic                     pslverr,
	input wire logic                     tx_enable,
	input wire logic                     rx_enable,
	input wire logic                     rx_irq_req,
	input wire logic                     err_irq_req,
	input wire logic                     tx_done_irq_req,
	input wire logic                     drop_char,
	input wire logic                     irq
);
	logic [7:0] ctl_sh;
	logic       wr_ctl;
	assign wr_ctl = apb_req.psel & apb_req.penable & apb_req.pwrite & pready & clk_en
		& (apb_req.paddr == sestc_pkg::SESTC_ADDR_CONTROL);
	always_ff @(posedge clock) begin
		if (sys_rst) ctl_sh <= 8'h00;
		else if (wr_ctl) ctl_sh <= apb_req.pwdata[7:0];
	end
	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);
	a_ready_wait: assert property (apb_req.psel && apb_req.penable && !$past(apb_req.penable) |-> !pready ##1 pready)
		else $error("pready not after one wait state");
	a_ready_pulse: assert property (pready |=> !pready) else $error("pready longer than one cycle");
	a_err_refused: assert property (pslverr |-> pready && prdata == 32'h0) else $error("bad error answer");
	a_tx_gate: assert property (wr_ctl |=> tx_enable == ctl_sh[sestc_pkg::SESTC_CTL_TX_EN])
		else $error("tx_enable not bit 5");
	a_rx_gate: assert property (wr_ctl |=> rx_enable == ctl_sh[sestc_pkg::SESTC_CTL_RX_EN])
		else $error("rx_enable not bit 4");
	a_tei_gate: assert property (tx_done_irq_req |-> ctl_sh[sestc_pkg::SESTC_CTL_TEI_EN])
		else $error("tei ungated");
	a_err_gate: assert property (err_irq_req |-> ctl_sh[sestc_pkg::SESTC_CTL_RXI_EN])
		else $error("err ungated");
	a_rxreq_gate: assert property (rx_irq_req |-> ctl_sh[sestc_pkg::SESTC_CTL_RXI_EN])
		else $error("rxi ungated");
	a_drop_cause: assert property (drop_char |-> $past(rx_ev.rx_done) || $past(rx_ev.rx_done, 2))
		else $error("drop without reception");
	c_ctl_write: cover property (wr_ctl);
	c_drop: cover property (drop_char);
	c_irq: cover property (irq);
endmodule // sestc_checker
bind sestc_top sestc_checker i_sestc_checker (.clock(clock), .sys_rst(sys_rst), .clk_en(clk_en), .apb_req(apb_req),
	.rx_ev(rx_ev), .prdata(prdata), .pready(pready), .pslverr(pslverr), .tx_enable(tx_enable), .rx_enable(rx_enable),
	.rx_irq_req(rx_irq_req), .err_irq_req(err_irq_req), .tx_done_irq_req(tx_done_irq_req), .drop_char(drop_char),
	.irq(irq));

//--- test/sestc_top_tb.sv
// Self-checking bench for the serial status block
// Assumes sestc_top, sestc_remote and the bound checker
`timescale 1ns/100ps
// ====================================================
// Bench
module sestc_top_tb;
	sestc_pkg::sestc_apb_req_t req;
	sestc_pkg::sestc_rx_ev_t   ev;
	logic                      clock, sys_rst, clk_en, pready, pslverr, err;
	logic                      tx_enable, rx_enable, rx_irq_req, err_irq_req, tx_done_irq_req, drop_char, irq;
	logic [2:0]                kind;
	logic [7:0]                b;
	logic [31:0]               prdata, rd;
	int                        n_mismatch, checked, drops;
	localparam logic [31:0] ST = sestc_pkg::SESTC_ADDR_STATUS;
	localparam logic [31:0] CT = sestc_pkg::SESTC_ADDR_CONTROL;
	localparam logic [31:0] MK = sestc_pkg::SESTC_ADDR_IRQ_MSK;
	sestc_top i_sestc_top (.clock(clock), .sys_rst(sys_rst), .clk_en(clk_en), .apb_req(req), .rx_ev(ev),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .tx_enable(tx_enable), .rx_enable(rx_enable),
		.rx_irq_req(rx_irq_req), .err_irq_req(err_irq_req), .tx_done_irq_req(tx_done_irq_req),
		.drop_char(drop_char), .irq(irq));
	sestc_remote i_sestc_remote (.clock(clock), .kind(kind), .ev(ev));
	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end
	always @(posedge clock) if (drop_char === 1'b1) drops++;
	task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge clock);
		req <= '{1'b1, 1'b0, w, a, d};
		@(posedge clock);
		req.penable <= 1'b1;
		do begin
			@(posedge clock);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
		repeat (2) @(posedge clock);
	endtask
	task automatic chk(input logic [31:0] v, input logic [31:0] e);
		checked++;
		if (v !== e) begin
			n_mismatch++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, v, e);
		end
	endtask
	task automatic st(input logic [7:0] e);
		apb(1'b0, ST, 32'h0);
		chk(rd, {24'h000000, e});
	endtask
	task automatic fire(input logic [2:0] k);
		@(posedge clock);
		kind <= k;
		@(posedge clock);
		kind <= 3'h0;
	endtask
	task wrap_up;
		$display("Comparisons %0d, mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		#60000;
		n_mismatch++;
		wrap_up;
	end
	initial begin
		clk_en = 1'b1;
		sys_rst = 1'b1;
		kind = 3'h0;
		req = '0;
		repeat (6) @(posedge clock);
		sys_rst <= 1'b0;
		st(8'h84);
		apb(1'b0, CT, 32'h0);
		chk(rd, 32'h0);
		apb(1'b1, CT, 32'h40);
		for (int k = 1; k < 4; k++) begin
			b = 8'h20 >> (k - 1);
			fire(3'(k));
			apb(1'b1, ST, {24'h000000, ~b});
			st(8'h84 | b);
			chk(32'(err_irq_req), 32'h1);
			apb(1'b1, ST, 32'hFF);
			st(8'h84 | b);
			apb(1'b1, ST, {24'h000000, ~b});
			st(8'h84);
			chk(32'(err_irq_req), 32'h0);
		end
		fire(3'h4);
		fire(3'h4);
		st(8'hE4);
		chk(32'(drops), 32'h1);
		chk(32'(rx_irq_req), 32'h1);
		apb(1'b1, ST, 32'h9F);
		st(8'h84);
		apb(1'b1, CT, 32'h24);
		chk(32'(tx_enable), 32'h1);
		fire(3'h5);
		st(8'h80);
		apb(1'b1, ST, 32'h7F);
		st(8'h00);
		fire(3'h6);
		st(8'h04);
		chk(32'(tx_done_irq_req), 32'h1);
		apb(1'b1, MK, 32'h8);
		chk(32'(irq), 32'h1);
		apb(1'b1, MK, 32'h0);
		chk(32'(irq), 32'h0);
		apb(1'b1, MK, 32'h8);
		apb(1'b1, sestc_pkg::SESTC_ADDR_IRQ_ST, 32'h8);
		chk(32'(irq), 32'h0);
		apb(1'b1, CT, 32'h20);
		chk(32'(tx_done_irq_req), 32'h0);
		apb(1'b1, CT, 32'h00);
		chk(32'(tx_enable), 32'h0);
		st(8'h84);
		apb(1'b0, 32'h0, 32'h0);
		chk({err, rd[30:0]}, 32'h80000000);
		apb(1'b0, MK, 32'h0);
		chk(rd, 32'h8);
		apb(1'b0, sestc_pkg::SESTC_ADDR_IRQ_ST, 32'h0);
		chk(rd, 32'h7);
		apb(1'b1, CT, 32'h10);
		chk(32'(rx_enable), 32'h1);
		apb(1'b0, CT, 32'h0);
		chk(rd, 32'h10);
		// Clock enable low: an overrun strobe must be ignored
		@(posedge clock);
		clk_en <= 1'b0;
		fire(3'h1);
		@(posedge clock);
		clk_en <= 1'b1;
		st(8'h84);
		// Reset in mid-run
		@(posedge clock);
		sys_rst <= 1'b1;
		repeat (2) @(posedge clock);
		sys_rst <= 1'b0;
		st(8'h84);
		apb(1'b0, CT, 32'h0);
		chk(rd, 32'h0);
		chk(32'(rx_enable), 32'h0);
		wrap_up;
	end
endmodule // sestc_top_tb
